//--- logic/aasc_top.sv
// Active-area scan control: resolution, start pointers, pixel shift, scan direction.
// Assumes a link decoder on the same clock delivering one parameter byte per wr_valid.
//
// Overview of operation
// - Columns are four times 160 to 415 by command, 480 at reset.
// - Lines are four times 120 to 270.
// - Command 80h takes column then line parameter.
// - Commands 2Ah and 2Bh set start pointers.
// - Secondary set page zero B4h shifts up to sixteen pixels either way.
// - Write-only scan control at command 36h.
// - Bit 3 picks BGR or RGB order.
// - Bit 1 low mirrors horizontally.
// - Bit 0 low flips vertically.
`timescale 1ns/1ps
`default_nettype none
`include "aasc_defs.svh"

module aasc_top (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             wr_valid,
    input  wire logic [15:0]      wr_addr,
    input  wire logic [7:0]       wr_data,
    input  wire logic             secondary_command_set,
    input  wire logic [3:0]       command_page,
    input  wire logic             frame_start,
    output logic [10:0]           active_columns,
    output logic [10:0]           active_lines,
    output logic [15:0]           horiz_start,
    output logic [15:0]           vert_start,
    output aasc_pkg::aasc_shift_type pixel_shift,
    output logic                  bgr_order,
    output logic                  horizontal_flip_n,
    output logic                  vertical_flip_n
);
    import aasc_pkg::*;

    default clocking dcb @(posedge clock); endclocking
    default disable iff (rst);

    aasc_cfg_type cfg_reg;
    aasc_cfg_type cfg_next;
    aasc_scan_if  scan ();

    // True when the byte addresses the given command and parameter index.
    function automatic logic hit(input logic [15:0] addr, input logic [7:0] cmd,
                                 input logic [7:0] idx);
        hit = (addr == {cmd, idx});
    endfunction

    // Column and line parameters widened to counts, then to sizes.
    function automatic logic [8:0] widen(input logic [7:0] prm, input logic [8:0] base);
        widen = {1'b0, prm} + base;
    endfunction

    logic       prim;
    logic       w_nc;
    logic       w_nl;
    logic       w_xs_hi;
    logic       w_xs_lo;
    logic       w_ys_hi;
    logic       w_ys_lo;
    logic       w_shift;
    logic       w_scan;
    logic [8:0] n_cnt;
    logic [8:0] m_cnt;
    logic       shift_ok;

    // Address decode; only the shift lives in the secondary set, page zero.
    assign prim    = wr_valid && !secondary_command_set;
    assign w_nc    = prim && hit(wr_addr, `AASC_CMD_RES, `AASC_IDX_0);
    assign w_nl    = prim && hit(wr_addr, `AASC_CMD_RES, `AASC_IDX_1);
    assign w_xs_hi = prim && hit(wr_addr, `AASC_CMD_XS, `AASC_IDX_0);
    assign w_xs_lo = prim && hit(wr_addr, `AASC_CMD_XS, `AASC_IDX_1);
    assign w_ys_hi = prim && hit(wr_addr, `AASC_CMD_YS, `AASC_IDX_0);
    assign w_ys_lo = prim && hit(wr_addr, `AASC_CMD_YS, `AASC_IDX_1);
    assign w_shift = wr_valid && secondary_command_set && command_page == `AASC_SHIFT_PAGE
                     && hit(wr_addr, `AASC_CMD_SHIFT, `AASC_IDX_0);
    assign w_scan  = prim && hit(wr_addr, `AASC_CMD_SCAN, `AASC_IDX_0);

    // Counts for the held column byte and the incoming line byte.
    assign n_cnt    = widen(cfg_reg.nc_hold, `AASC_NC_BASE);
    assign m_cnt    = widen(wr_data, `AASC_NL_BASE);
    assign shift_ok = ($signed(wr_data) <= $signed(`AASC_SHIFT_MAX))
                   && ($signed(wr_data) >= -$signed(`AASC_SHIFT_MAX));

    // Next-state logic. The two resolution bytes commit together so the panel never
    // runs with a new width and an old height; an out-of-range pair is dropped whole.
    always_comb begin
        cfg_next = cfg_reg;
        cfg_next.scan_new = 1'b0;
        if (w_nc) begin
            cfg_next.nc_hold = wr_data;
            cfg_next.nc_seen = 1'b1;
        end
        if (w_nl && cfg_reg.nc_seen) begin
            cfg_next.nc_seen = 1'b0;
            if (n_cnt <= `AASC_N_MAX && m_cnt <= `AASC_M_MAX) begin
                cfg_next.cols  = {n_cnt, 2'b00};
                cfg_next.lines = {m_cnt, 2'b00};
            end
        end
        if (w_xs_hi) begin
            cfg_next.xs_hi = wr_data;
        end
        if (w_xs_lo) begin
            cfg_next.hs = {cfg_reg.xs_hi, wr_data};
        end
        if (w_ys_hi) begin
            cfg_next.ys_hi = wr_data;
        end
        if (w_ys_lo) begin
            cfg_next.vs = {cfg_reg.ys_hi, wr_data};
        end
        if (w_shift && shift_ok) begin
            cfg_next.shift = aasc_shift_type'(wr_data[5:0]);
        end
        if (w_scan) begin
            // Only the three defined bits are kept; the rest of the byte is dropped.
            cfg_next.scan_pend = {wr_data[`AASC_BIT_BGR], wr_data[`AASC_BIT_HFLIP_N],
                                  wr_data[`AASC_BIT_VFLIP_N]};
            cfg_next.scan_new  = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_reg <= '{cols: `AASC_COLS_RST, lines: `AASC_LINES_RST, nc_hold: 8'h00,
                         nc_seen: 1'b0, xs_hi: 8'h00, ys_hi: 8'h00, hs: `AASC_START_RST,
                         vs: `AASC_START_RST, shift: `AASC_SHIFT_RST,
                         scan_pend: `AASC_SCAN_RST, scan_new: 1'b0};
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Scan bits pass through the frame latch before reaching the panel drivers.
    assign scan.pending     = cfg_reg.scan_pend;
    assign scan.load        = cfg_reg.scan_new;
    assign scan.frame_start = frame_start;

    aasc_scan_latch u_latch (
        .clock (clock),
        .rst   (rst),
        .scan  (scan)
    );

    // Outputs; all come from flip-flops.
    assign active_columns    = cfg_reg.cols;
    assign active_lines      = cfg_reg.lines;
    assign horiz_start       = cfg_reg.hs;
    assign vert_start        = cfg_reg.vs;
    assign pixel_shift       = cfg_reg.shift;
    assign bgr_order         = scan.applied[2];
    assign horizontal_flip_n = scan.applied[1];
    assign vertical_flip_n   = scan.applied[0];

    // Checks on the configuration outputs and the scan latch inputs; clock and reset come from the defaults above.
    AST_COL_RANGE: assert property (
        active_columns[1:0] == 2'b00 && active_columns >= `AASC_COLS_MIN
        && active_columns <= `AASC_COLS_MAX)
        else $error("Active column count off grid or out of range.");

    AST_LINE_RANGE: assert property (
        active_lines[1:0] == 2'b00 && active_lines >= `AASC_LINES_MIN
        && active_lines <= `AASC_LINES_MAX)
        else $error("Active line count off grid or out of range.");

    AST_RES_PAIR: assert property (
        w_nl && cfg_reg.nc_seen && m_cnt <= `AASC_M_MAX
        |=> active_lines == {$past(m_cnt), 2'b00} && active_columns == {$past(n_cnt), 2'b00})
        else $error("Resolution pair not committed.");

    AST_RES_NEEDS_NC: assert property (
        w_nl && !cfg_reg.nc_seen |=> $stable(active_lines) && $stable(active_columns))
        else $error("Line byte without column byte changed the size.");

    // A refused pair must leave the old size in place, not half of the new one.
    AST_RES_DROP: assert property (
        w_nl && cfg_reg.nc_seen && m_cnt > `AASC_M_MAX
        |=> $stable(active_lines) && $stable(active_columns))
        else $error("Out-of-range line byte changed the size.");

    AST_XS_LOAD: assert property (
        w_xs_hi ##1 (w_xs_lo && !w_xs_hi)
        |=> horiz_start == {$past(wr_data, 2), $past(wr_data)})
        else $error("Horizontal start not loaded high then low.");

    AST_YS_LOAD: assert property (
        w_ys_lo |=> vert_start[7:0] == $past(wr_data))
        else $error("Vertical start low byte not loaded.");

    AST_SHIFT_BOUND: assert property (
        pixel_shift <= 6'sd16 && pixel_shift >= -6'sd16)
        else $error("Pixel shift outside sixteen pixels.");

    AST_SHIFT_PAGE: assert property (
        wr_valid && !secondary_command_set |=> $stable(pixel_shift))
        else $error("Pixel shift changed from the primary set.");

    // An out-of-range shift byte is dropped; clamping it would move the image silently.
    AST_SHIFT_REFUSE: assert property (
        w_shift && !shift_ok |=> $stable(pixel_shift))
        else $error("Refused shift byte changed the pixel shift.");

    AST_SCAN_FIELDS: assert property (
        w_scan |=> scan.load && scan.pending == {$past(wr_data[3]), $past(wr_data[1]),
                                                 $past(wr_data[0])})
        else $error("Scan byte fields mapped wrongly.");

    AST_SCAN_TO_PINS: assert property (
        frame_start && scan.load |=> {bgr_order, horizontal_flip_n, vertical_flip_n}
                                     == $past(scan.pending))
        else $error("Scan bits not driven at frame start.");

    COV_RESOLUTION: cover property (w_nc ##[1:4] w_nl);
    COV_SHIFT_NEG: cover property (w_shift && shift_ok && wr_data[7]);
    COV_MIRROR: cover property (!horizontal_flip_n && !vertical_flip_n && bgr_order);
    COV_SCAN_SAME_CYCLE: cover property (frame_start && scan.load);

endmodule

`default_nettype wire

//--- logic/aasc_defs.svh
// Command codes, field positions, reset values and limits of the active-area scan control.
// Assumes a link decoder that presents each parameter byte as a 16-bit command/index address.
`ifndef AASC_DEFS_SVH
`define AASC_DEFS_SVH

// Command codes; the low address byte is the parameter index within the command.
`define AASC_CMD_RES       8'h80
`define AASC_CMD_XS        8'h2a
`define AASC_CMD_YS        8'h2b
`define AASC_CMD_SHIFT     8'hb4
`define AASC_CMD_SCAN      8'h36
`define AASC_IDX_0         8'h00
`define AASC_IDX_1         8'h01
`define AASC_SHIFT_PAGE    4'h0

// Resolution coding: count = base + parameter, size = 4 * count.
`define AASC_NC_BASE       9'h0a0
`define AASC_NL_BASE       9'h078
`define AASC_N_MAX         9'h1e0
`define AASC_M_MAX         9'h10e
`define AASC_COLS_MIN      11'h280
`define AASC_COLS_MAX      11'h780
`define AASC_LINES_MIN     11'h1e0
`define AASC_LINES_MAX     11'h438

// Pixel shift limit in pixels, either direction.
`define AASC_SHIFT_MAX     8'h10

// Scan-direction field positions in the written byte.
`define AASC_BIT_BGR       3
`define AASC_BIT_HFLIP_N   1
`define AASC_BIT_VFLIP_N   0

// Reset values.
`define AASC_COLS_RST      11'h780
`define AASC_LINES_RST     11'h438
`define AASC_START_RST     16'h0000
`define AASC_SHIFT_RST     6'h00
`define AASC_SCAN_RST      3'h3

`endif

//--- logic/aasc_pkg.sv
// Types shared by the active-area scan control modules.
// Assumes aasc_defs.svh is on the include path.
`default_nettype none

package aasc_pkg;

    typedef logic signed [5:0] aasc_shift_type;
    typedef logic [10:0]       aasc_size_type;
    typedef logic [2:0]        aasc_scan_type;

    // Configuration state of the main module.
    typedef struct packed {
        aasc_size_type  cols;
        aasc_size_type  lines;
        logic [7:0]     nc_hold;
        logic           nc_seen;
        logic [7:0]     xs_hi;
        logic [7:0]     ys_hi;
        logic [15:0]    hs;
        logic [15:0]    vs;
        aasc_shift_type shift;
        aasc_scan_type  scan_pend;
        logic           scan_new;
    } aasc_cfg_type;

    // State of the frame-aligned scan latch.
    typedef struct packed {
        aasc_scan_type applied;
        logic          armed;
    } aasc_latch_type;

endpackage

`default_nettype wire

//--- logic/aasc_scan_if.sv
// Carrier between the command decoder and the frame-aligned scan latch.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface aasc_scan_if;
    import aasc_pkg::*;
    aasc_scan_type pending;
    logic          load;
    logic          frame_start;
    aasc_scan_type applied;

    modport src (output pending, output load, output frame_start, input applied);
    modport dst (input pending, input load, input frame_start, output applied);
endinterface

`default_nettype wire

//--- logic/aasc_scan_latch.sv
// Frame-aligned latch for the scan-direction and colour-order bits.
// Assumes frame_start is a one-cycle pulse on the same clock at each frame's first line.
`timescale 1ns/1ps
`default_nettype none
`include "aasc_defs.svh"

module aasc_scan_latch (
    input  wire logic    clock,
    input  wire logic    rst,
    aasc_scan_if.dst     scan
);
    import aasc_pkg::*;

    aasc_latch_type st_reg;
    aasc_latch_type st_next;

    // A new setting waits for the next frame so a frame is never drawn half mirrored.
    always_comb begin
        st_next = st_reg;
        if (scan.load) begin
            st_next.armed = 1'b1;
        end
        if (scan.frame_start && (st_reg.armed || scan.load)) begin
            st_next.applied = scan.pending;
            st_next.armed   = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= '{applied: `AASC_SCAN_RST, armed: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign scan.applied = st_reg.applied;

    AST_HOLD_MIDFRAME: assert property (@(posedge clock) disable iff (rst)
        !scan.frame_start |=> $stable(scan.applied))
        else $error("Scan bits changed outside a frame start.");

    AST_APPLY_AT_FRAME: assert property (@(posedge clock) disable iff (rst)
        scan.load ##[0:50] scan.frame_start |=> scan.applied == $past(scan.pending))
        else $error("Pending scan bits not applied at frame start.");

    COV_APPLY: cover property (@(posedge clock) disable iff (rst)
        scan.load ##[1:20] scan.frame_start);

endmodule

`default_nettype wire

//--- sim/aasc_host.sv
// Host model: offers parameter bytes and frame pulses to the scan control.
// Assumes one bench process calls its tasks, all on the shared clock.
`timescale 1ns/1ps
`default_nettype none

module aasc_host (
    input  wire logic   clock,
    output logic        wr_valid,
    output logic [15:0] wr_addr,
    output logic [7:0]  wr_data,
    output logic        secondary_command_set,
    output logic [3:0]  command_page,
    output logic        frame_start
);
    // Idle levels at time zero.
    initial begin
        wr_valid = 1'b0;
        wr_addr = 16'hffff;
        wr_data = 8'hff;
        secondary_command_set = 1'b0;
        command_page = 4'h0;
        frame_start = 1'b0;
    end

    // One byte per call; once released, address and data show inverted values,
    // so a design sampling outside wr_valid sees garbage rather than stale data.
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic s,
                      input logic [3:0] p);
        @(posedge clock);
        wr_valid <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        secondary_command_set <= s;
        command_page <= p;
        @(posedge clock);
        wr_valid <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask

    // Index 0 then index 1 of one command on consecutive edges, with no idle cycle.
    task automatic wr_pair(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
        @(posedge clock);
        wr_valid <= 1'b1;
        wr_addr <= {cmd, 8'h00};
        wr_data <= d0;
        secondary_command_set <= 1'b0;
        command_page <= 4'h0;
        @(posedge clock);
        wr_addr <= {cmd, 8'h01};
        wr_data <= d1;
        @(posedge clock);
        wr_valid <= 1'b0;
        wr_addr <= ~{cmd, 8'h01};
        wr_data <= ~d1;
    endtask

    // Column byte then line byte, offsets from 160 and 120.
    task automatic res(input logic [7:0] nc, input logic [7:0] nl);
        wr(16'h8000, nc, 1'b0, 4'h0);
        wr(16'h8001, nl, 1'b0, 4'h0);
    endtask

    // One-cycle frame pulse after lead edges; a lead of zero, called right after a
    // write, lands the pulse on the cycle in which that write raises its load pulse.
    task automatic frame(input int lead);
        repeat (lead) @(posedge clock);
        frame_start <= 1'b1;
        @(posedge clock);
        frame_start <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the active-area scan control top module.
// Assumes the host model in aasc_host.sv and the design files under logic/.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import aasc_pkg::*;
    logic           clock;
    logic           rst;
    logic           wr_valid;
    logic [15:0]    wr_addr;
    logic [7:0]     wr_data;
    logic           sec;
    logic [3:0]     page;
    logic           frame_start;
    logic [10:0]    cols;
    logic [10:0]    lines;
    logic [15:0]    hs;
    logic [15:0]    vs;
    aasc_shift_type shift;
    logic           bgr;
    logic           hflip_n;
    logic           vflip_n;
    logic [10:0]    e_c;
    logic [10:0]    e_l;
    logic [15:0]    e_h;
    logic [15:0]    e_v;
    logic [5:0]     e_s;
    logic [2:0]     e_sc;
    int             fails;
    int             n_compared;

    aasc_top u_aasc_top (.clock(clock), .rst(rst), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .secondary_command_set(sec), .command_page(page),
        .frame_start(frame_start), .active_columns(cols), .active_lines(lines),
        .horiz_start(hs), .vert_start(vs), .pixel_shift(shift), .bgr_order(bgr),
        .horizontal_flip_n(hflip_n), .vertical_flip_n(vflip_n));

    aasc_host u_aasc_host (.clock(clock), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .secondary_command_set(sec), .command_page(page),
        .frame_start(frame_start));

    // 20 MHz clock.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // All outputs against the expected state, mid-cycle so edge updates have landed.
    task automatic see();
        @(negedge clock);
        chk("active_columns", {5'h00, e_c}, {5'h00, cols});
        chk("active_lines", {5'h00, e_l}, {5'h00, lines});
        chk("horiz_start", e_h, hs);
        chk("vert_start", e_v, vs);
        chk("pixel_shift", {10'h000, e_s}, {10'h000, shift});
        chk("scan_bits", {13'h0000, e_sc}, {13'h0000, bgr, hflip_n, vflip_n});
    endtask

    task automatic t_reset();
        e_c = 11'h780;
        e_l = 11'h438;
        e_h = 16'h0000;
        e_v = 16'h0000;
        e_s = 6'h00;
        e_sc = 3'h3;
        see();
        u_aasc_host.wr(16'h3700, 8'h00, 1'b0, 4'h0);
        see();
        $display("test reset done");
    endtask

    // Both count limits, then an out-of-range line byte and an orphan line byte.
    task automatic t_res();
        u_aasc_host.res(8'h00, 8'h00);
        e_c = 11'(4 * 160);
        e_l = 11'(4 * 120);
        see();
        u_aasc_host.res(8'hff, 8'h96);
        e_c = 11'(4 * 415);
        e_l = 11'(4 * 270);
        see();
        u_aasc_host.res(8'h10, 8'h97);
        see();
        u_aasc_host.wr(16'h8001, 8'h00, 1'b0, 4'h0);
        see();
        $display("test resolution done");
    endtask

    task automatic t_start();
        u_aasc_host.wr_pair(8'h2a, 8'h12, 8'h34);
        u_aasc_host.wr(16'h2b00, 8'h56, 1'b0, 4'h0);
        u_aasc_host.wr(16'h2b01, 8'h78, 1'b0, 4'h0);
        e_h = 16'h1234;
        e_v = 16'h5678;
        see();
        $display("test start pointer done");
    endtask

    task automatic sh(input logic [7:0] d, input logic s, input logic [3:0] p,
                      input logic [5:0] e);
        u_aasc_host.wr(16'hb400, d, s, p);
        e_s = e;
        see();
    endtask

    // Shift limits, one step past each, wrong set and wrong page.
    task automatic t_shift();
        sh(8'hf0, 1'b1, 4'h0, 6'h30);
        sh(8'h10, 1'b1, 4'h0, 6'h10);
        sh(8'h11, 1'b1, 4'h0, 6'h10);
        sh(8'hef, 1'b1, 4'h0, 6'h10);
        sh(8'h05, 1'b0, 4'h0, 6'h10);
        sh(8'h05, 1'b1, 4'h1, 6'h10);
        sh(8'h05, 1'b1, 4'h0, 6'h05);
        $display("test pixel shift done");
    endtask

    // Every combination of the three used bits, with unused bits 7, 5 and 2 set around them.
    task automatic t_scan();
        logic [2:0] i;
        for (int k = 0; k < 8; k++) begin
            i = 3'(k);
            u_aasc_host.wr(16'h3600, {4'ha, i[2], 1'b1, i[1], i[0]}, 1'b0, 4'h0);
            see();
            u_aasc_host.frame(2);
            e_sc = i;
            see();
        end
        // Frame pulse in the very cycle of the load pulse still applies the new bits.
        u_aasc_host.wr(16'h3600, 8'h08, 1'b0, 4'h0);
        u_aasc_host.frame(0);
        e_sc = 3'h4;
        see();
        $display("test scan direction done");
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence.
    initial begin
        fails = 0;
        n_compared = 0;
        rst = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_res();
        t_start();
        t_shift();
        t_scan();
        give_verdict();
    end

    // Bounds the whole run in case a task hangs.
    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        $display("ERROR run_length expected finish seen timeout");
        give_verdict();
    end
endmodule

`default_nettype wire
